/* File: include/ctsc_pkg.sv */
// Purpose: shared constants and types of the cap trellis scrambler codec
// Assumes: one 200 MHz clock; symbol rate derived by a phase accumulator
// Notes:   tap indices are history positions, bit 0 holding the newest bit
`default_nettype none
package ctsc_pkg;
  localparam int           HIST_W        = 23;
  localparam int           TAP_LONG      = 22;  // x^-23
  localparam int           TAP_CUST      = 17;  // x^-18
  localparam int           TAP_EXCH      = 4;   // x^-5
  localparam int           CW_W          = 7;
  localparam int           TREL_W        = 3;
  localparam int           CNT_W         = 3;
  localparam logic [2:0]   GRP_TWO_PAIR  = 3'h5;
  localparam logic [2:0]   GRP_ONE_PAIR  = 3'h6;
  localparam logic [2:0]   GRP_UNCODED_X = 3'h1;
  localparam logic [22:0]  HIST_RST      = 23'h000000;
  localparam logic [2:0]   TREL_RST      = 3'h0;
  localparam longint       CLK_HZ        = 200_000_000;
  localparam longint       SYM_HZ_64     = 233_600;  // 1 168 kbit/s, 110 ppm
  localparam longint       SYM_HZ_128    = 386_667;  // 2 320 kbit/s, 90 ppm
  localparam int           PPM_64        = 110;
  localparam int           PPM_128       = 90;
  localparam int           ACC_W         = 32;
  // accumulator step; quantisation error is below 1 ppm, well inside tolerance
  localparam logic [31:0]  NCO_INC_64    = 32'((SYM_HZ_64 * (64'h1 << ACC_W)) / CLK_HZ);
  localparam logic [31:0]  NCO_INC_128   = 32'((SYM_HZ_128 * (64'h1 << ACC_W)) / CLK_HZ);
  typedef enum logic [0:0] {
    CTSC_SELF_SYNC = 1'b0,
    CTSC_LOCKED    = 1'b1
  } ctsc_scr_mode_t;
endpackage : ctsc_pkg
`default_nettype wire

/* File: verification/ctsc_line_partner.sv */
// Purpose: far-end line model; loops every transmitted code word back as a received word
// Assumes: one word per valid pulse, returned one clock later
// Notes:   between words the returned code flips so stale values never look valid
`default_nettype none
module ctsc_line_partner (
  input  wire logic       i_mclk,
  input  wire logic [6:0] i_code,
  input  wire logic       i_code_vld,
  output logic      [6:0] o_code,
  output logic            o_code_vld
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_code     = 7'h00;
    o_code_vld = 1'b0;
  end
  // every word goes back untouched, so all frame bits take the full scramble path
  always @(posedge i_mclk) begin
    o_code_vld <= i_code_vld;
    o_code     <= i_code_vld ? i_code : ~o_code;
  end
endmodule // ctsc_line_partner
`default_nettype wire

/* File: verification/test_ctsc_codec.sv */
// Purpose: self-checking bench for the scrambler, grouping and trellis codec
// Assumes: symbol accumulator sped up to one symbol per 16 clocks
// Notes:   the line partner loops words back, so receive output must equal sent bits
`default_nettype none
module test_ctsc_codec;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_mclk = 1'b0, i_rst_b = 1'b0, i_one_pair = 1'b0, i_exchange_side = 1'b0;
  logic       i_coded = 1'b1, i_lock_req = 1'b0, i_tx_bit = 1'b0, i_tx_vld = 1'b0;
  logic       o_tx_bit_rdy, o_tx_code_vld, o_sym_tick, o_tx_locked, i_rx_vld, o_rx_vld, o_rx_locked;
  logic [6:0] o_tx_code, i_rx_code, o_rx_data;
  logic [2:0] o_rx_len;
  int         bad_count = 0, num_checks = 0;
  logic [6:0] txq[$], rxq[$];
  logic [2:0] lenq[$];
  localparam logic [31:0] PAT = 32'hB3C5_96E1;

  always #2.5 i_mclk = ~i_mclk;

  ctsc_codec #(.NCO_INC_2PAIR(32'h1000_0000), .NCO_INC_1PAIR(32'h1000_0000)) ctsc_codec_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_one_pair(i_one_pair), .i_exchange_side(i_exchange_side),
    .i_coded(i_coded), .i_lock_req(i_lock_req), .i_tx_bit(i_tx_bit), .i_tx_vld(i_tx_vld),
    .o_tx_bit_rdy(o_tx_bit_rdy), .o_tx_code(o_tx_code), .o_tx_code_vld(o_tx_code_vld),
    .o_sym_tick(o_sym_tick), .o_tx_locked(o_tx_locked), .i_rx_code(i_rx_code), .i_rx_vld(i_rx_vld),
    .o_rx_data(o_rx_data), .o_rx_len(o_rx_len), .o_rx_vld(o_rx_vld), .o_rx_locked(o_rx_locked));

  ctsc_line_partner ctsc_line_partner_inst (
    .i_mclk(i_mclk), .i_code(o_tx_code), .i_code_vld(o_tx_code_vld),
    .o_code(i_rx_code), .o_code_vld(i_rx_vld));

  always @(posedge i_mclk) begin
    if (o_tx_code_vld === 1'b1) txq.push_back(o_tx_code);
    if (o_rx_vld === 1'b1) begin
      rxq.push_back(o_rx_data);
      lenq.push_back(o_rx_len);
    end
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [6:0] got, input logic [6:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic timeout(input string msg);
    bad_count++;
    $display("CHECK FAILED %0t timeout %s", $time, msg);
    tally_and_finish();
  endtask

  task automatic do_reset();
    i_rst_b <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(posedge i_mclk);
    txq.delete();
    rxq.delete();
    lenq.delete();
  endtask

  // rdy is combinational and settles between edges, so it is sampled on the falling edge
  task automatic send_bit(input logic b);
    logic ok;
    ok = 1'b0;
    i_tx_vld <= 1'b1;
    i_tx_bit <= b;
    for (int w = 0; w < 200 && !ok; w++) begin
      @(negedge i_mclk);
      ok = (o_tx_bit_rdy === 1'b1);
      @(posedge i_mclk);
    end
    if (!ok) timeout("tx ready");
  endtask

  task automatic run_groups(input int glen, input int n);
    logic [22:0] h;
    logic [2:0]  st;
    logic [6:0]  g, s, expq[$], datq[$];
    logic        b, sb;
    int          tap, w;
    h = ctsc_pkg::HIST_RST;
    st = ctsc_pkg::TREL_RST;
    tap = i_exchange_side ? ctsc_pkg::TAP_EXCH : ctsc_pkg::TAP_CUST;
    for (int k = 0; k < n; k++) begin
      g = 7'h00;
      s = 7'h00;
      for (int i = 0; i < glen; i++) begin
        b = PAT[(k * glen + i) % 32];
        g[i] = b;
        send_bit(b);
        sb = b ^ h[tap] ^ h[ctsc_pkg::TAP_LONG];
        s[i] = sb;
        h = {h[21:0], sb};
      end
      if (i_coded) begin
        expq.push_back({s[5:0], st[0]});
        st = {st[0] ^ s[0], st[2] ^ s[1], st[1] ^ s[0]};
      end
      else expq.push_back(s);
      datq.push_back(g);
    end
    i_tx_vld <= 1'b0;
    for (w = 0; w < 2000 && (txq.size() < n || rxq.size() < n); w++) @(posedge i_mclk);
    if (w == 2000) timeout("words");
    for (int k = 0; k < n; k++) begin
      check(txq[k], expq[k], "tx code word");
      check(rxq[k], datq[k], "rx data");
      check({4'h0, lenq[k]}, 7'(glen), "rx length");
    end
  endtask

  task automatic sc_reset_values();
    do_reset();
    check({4'h0, o_tx_bit_rdy, o_tx_locked, o_rx_locked}, 7'h04, "idle after reset");
  endtask

  task automatic sc_coded_two_pair_customer();
    i_one_pair <= 1'b0;
    i_exchange_side <= 1'b0;
    i_coded <= 1'b1;
    do_reset();
    run_groups(5, 8);
  endtask

  task automatic sc_coded_one_pair_exchange();
    i_one_pair <= 1'b1;
    i_exchange_side <= 1'b1;
    i_coded <= 1'b1;
    do_reset();
    run_groups(6, 6);
  endtask

  task automatic sc_uncoded_start_up();
    i_one_pair <= 1'b0;
    i_exchange_side <= 1'b1;
    i_coded <= 1'b0;
    do_reset();
    run_groups(6, 5);
  endtask

  task automatic sc_lock_on_ones();
    int w;
    i_one_pair <= 1'b0;
    i_coded <= 1'b1;
    i_lock_req <= 1'b1;
    do_reset();
    for (int i = 0; i < 10; i++) send_bit(1'b1);
    i_tx_vld <= 1'b0;
    for (w = 0; w < 400 && (o_rx_locked !== 1'b1 || rxq.size() < 2); w++) @(posedge i_mclk);
    check({5'h00, o_tx_locked, o_rx_locked}, 7'h03, "both ends locked");
    check(rxq.size() > 0 ? rxq[0] : 7'h00, 7'h1F, "first ones word");
    check(rxq.size() > 1 ? rxq[1] : 7'h00, 7'h1F, "locked ones word");
    i_lock_req <= 1'b0;
    repeat (3) @(posedge i_mclk);
    check({5'h00, o_tx_locked, o_rx_locked}, 7'h00, "back to self sync");
  endtask

  initial begin
    sc_reset_values();
    sc_coded_two_pair_customer();
    sc_coded_one_pair_exchange();
    sc_uncoded_start_up();
    sc_lock_on_ones();
    tally_and_finish();
  end
endmodule // test_ctsc_codec
`default_nettype wire

/* File: verilog/ctsc_codec.sv */
// Purpose: scrambler, symbol grouping and trellis redundancy for a CAP line codec
// Assumes: bit streams synchronous to i_mclk; receive words already sliced
// Notes:   constellation lookup and precoding sit downstream of o_tx_code
// Operation
// RQ1: line code is trellis-coded CAP with Tomlinson precoding before transmission.
// RQ2: 1 168 kbit/s uses coded 64-point, 2 320 kbit/s uses coded 128-point.
// RQ3: start-up transmits uncoded, without trellis redundancy, then switches to coded.
// RQ4: eight-state two-dimensional code, no differential encoding.
// RQ5: exactly one redundant bit per symbol; six or seven bits per symbol total.
// RQ6: two-pair groups are five bits, earliest bit is least significant.
// RQ7: first two group bits feed a systematic encoder producing the redundant bit.
// RQ8: two-pair code word is redundant bit then five group bits, bits zero to five.
// RQ9: one-pair uses six-bit groups forming a seven-bit code word.
// RQ10: customer side polynomial is one plus x^-18 plus x^-23.
// RQ11: exchange side polynomial is one plus x^-5 plus x^-23.
// RQ12: self-synchronizing transmit divides the stream by the polynomial.
// RQ13: self-synchronizing receive multiplies the stream by the polynomial.
// RQ14: locked mode adds the generated sequence on transmit, removes it on receive.
// RQ15: each end enters locked mode on ones data, with no coordination.
// RQ16: every frame bit, overhead, sync and stuffing, is scrambled.
// RQ17: symbol clock 233,60 kbaud within 110 ppm or 386,667 kbaud within 90 ppm.
// RQ18: frame length varies with stuffing, so symbols per frame vary.
// RQ19: code word mapping and encoder taps by lookup and three-bit state.
// RQ20: each scrambler holds 23 bits of history, cleared at reset.
`default_nettype none
module ctsc_codec #(
  parameter logic [31:0] NCO_INC_2PAIR = ctsc_pkg::NCO_INC_64,
  parameter logic [31:0] NCO_INC_1PAIR = ctsc_pkg::NCO_INC_128
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_one_pair,
  input  wire logic       i_exchange_side,
  input  wire logic       i_coded,
  input  wire logic       i_lock_req,
  input  wire logic       i_tx_bit,
  input  wire logic       i_tx_vld,
  output logic            o_tx_bit_rdy,
  output logic [6:0]      o_tx_code,
  output logic            o_tx_code_vld,
  output logic            o_sym_tick,
  output logic            o_tx_locked,
  input  wire logic [6:0] i_rx_code,
  input  wire logic       i_rx_vld,
  output logic [6:0]      o_rx_data,
  output logic [2:0]      o_rx_len,
  output logic            o_rx_vld,
  output logic            o_rx_locked
);
  typedef struct packed {
    logic [31:0]              acc;
    logic                     sym_tick;
    logic [22:0]              tx_hist;
    ctsc_pkg::ctsc_scr_mode_t tx_mode;
    logic [6:0]               tx_grp;
    logic [2:0]               tx_cnt;
    logic                     tx_full;
    logic [2:0]               tx_trel;
    logic [6:0]               tx_code;
    logic                     code_vld;
    logic [22:0]              rx_hist;
    ctsc_pkg::ctsc_scr_mode_t rx_mode;
    logic [6:0]               rx_data;
    logic [2:0]               rx_len;
    logic                     rx_vld;
  } ctsc_state_t;

  ctsc_state_t s;
  ctsc_state_t next_s;
  logic        red_bit;
  logic [2:0]  trel_next;

  // feedback of the direction-specific polynomial, both taps from history
  function automatic logic tap_fn(input logic [22:0] h, input logic exch);
    logic t;
    t = exch ? h[ctsc_pkg::TAP_EXCH] : h[ctsc_pkg::TAP_CUST]; // see RQ11 see RQ10
    return t ^ h[ctsc_pkg::TAP_LONG];
  endfunction

  // bits per symbol: five or six info bits coded, one more while uncoded
  function automatic logic [2:0] grp_len_fn(input logic one_pair, input logic coded);
    logic [2:0] b;
    b = one_pair ? ctsc_pkg::GRP_ONE_PAIR : ctsc_pkg::GRP_TWO_PAIR; // see RQ6 see RQ9
    return coded ? b : 3'(b + ctsc_pkg::GRP_UNCODED_X);               // see RQ3
  endfunction

  ctsc_trellis_enc ctsc_trellis_enc_inst (
    .i_state                 (s.tx_trel),
    .i_group_first_info_bit  (s.tx_grp[0]),
    .i_group_second_info_bit (s.tx_grp[1]),
    .o_trellis_redundant_bit (red_bit),
    .o_next_state            (trel_next)
  ); // see RQ7 see RQ4 see RQ19

  always_comb begin
    logic                     fb;
    logic                     sb;
    logic                     d;
    logic                     carry;
    logic [31:0]              inc;
    logic [31:0]              sum;
    logic [22:0]              h;
    ctsc_pkg::ctsc_scr_mode_t m;
    logic [6:0]               info;
    logic [6:0]               data;
    logic [2:0]               glen;
    fb     = 1'b0;
    sb     = 1'b0;
    d      = 1'b0;
    carry  = 1'b0;
    inc    = 32'h0000_0000;
    sum    = 32'h0000_0000;
    glen   = 3'h0;
    h      = s.rx_hist;
    m      = s.rx_mode;
    info   = 7'h00;
    data   = 7'h00;
    next_s = s;
    next_s.code_vld = 1'b0;
    next_s.rx_vld   = 1'b0;
    glen = grp_len_fn(i_one_pair, i_coded);

    // symbol rate by phase accumulator; carry is the one-cycle symbol enable
    inc = i_one_pair ? NCO_INC_1PAIR : NCO_INC_2PAIR; // see RQ17 see RQ2
    {carry, sum} = {1'b0, s.acc} + {1'b0, inc};
    next_s.acc      = sum;
    next_s.sym_tick = carry;

    // transmit: every offered bit is scrambled, no bypass exists
    if (i_tx_vld && !s.tx_full) begin
      fb = tap_fn(s.tx_hist, i_exchange_side);
      sb = i_tx_bit ^ fb; // see RQ16
      if (s.tx_mode == ctsc_pkg::CTSC_LOCKED) begin
        next_s.tx_hist = {s.tx_hist[21:0], fb}; // see RQ14
      end else begin
        next_s.tx_hist = {s.tx_hist[21:0], sb}; // see RQ12
        if (i_lock_req && i_tx_bit) begin
          next_s.tx_mode = ctsc_pkg::CTSC_LOCKED; // see RQ15
        end
      end
      next_s.tx_grp[s.tx_cnt] = sb; // see RQ6
      if (s.tx_cnt == 3'(glen - 3'h1)) begin
        next_s.tx_cnt  = 3'h0;
        next_s.tx_full = 1'b1;
      end else begin
        next_s.tx_cnt = 3'(s.tx_cnt + 3'h1);
      end
    end
    if (!i_lock_req) begin
      next_s.tx_mode = ctsc_pkg::CTSC_SELF_SYNC;
    end

    // groups run on across frame boundaries; stuffing only changes the count
    if (carry && s.tx_full) begin // see RQ18
      if (i_coded) begin
        next_s.tx_code = {s.tx_grp[5:0], red_bit}; // see RQ8 see RQ9 see RQ5
        next_s.tx_trel = trel_next;                 // see RQ19
      end else begin
        next_s.tx_code = s.tx_grp; // see RQ3
        next_s.tx_trel = ctsc_pkg::TREL_RST;
      end
      next_s.tx_grp   = 7'h00;
      next_s.tx_full  = 1'b0;
      next_s.code_vld = 1'b1; // see RQ1
    end

    // receive: drop the redundant bit, then descramble lsb first
    // no viterbi decision here: words arrive already sliced, so a bad slice
    // corrupts, in self-sync mode, the descrambled bits at the tap distances as well
    if (i_rx_vld) begin
      info = i_coded ? {1'b0, i_rx_code[6:1]} : i_rx_code; // see RQ5
      for (int k = 0; k < ctsc_pkg::CW_W; k++) begin
        if (k < int'(glen)) begin
          fb = tap_fn(h, i_exchange_side);
          d  = info[k] ^ fb;
          if (m == ctsc_pkg::CTSC_LOCKED) begin
            h = {h[21:0], fb}; // see RQ14
          end else begin
            h = {h[21:0], info[k]}; // see RQ13
            if (i_lock_req && d) begin
              m = ctsc_pkg::CTSC_LOCKED; // see RQ15
            end
          end
          data[k] = d;
        end
      end
      next_s.rx_hist = h;
      next_s.rx_data = data;
      next_s.rx_len  = glen;
      next_s.rx_vld  = 1'b1;
    end
    next_s.rx_mode = i_lock_req ? m : ctsc_pkg::CTSC_SELF_SYNC;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s         <= '0;
      s.tx_hist <= ctsc_pkg::HIST_RST; // see RQ20
      s.rx_hist <= ctsc_pkg::HIST_RST; // see RQ20
      s.tx_trel <= ctsc_pkg::TREL_RST;
      s.tx_mode <= ctsc_pkg::CTSC_SELF_SYNC;
      s.rx_mode <= ctsc_pkg::CTSC_SELF_SYNC;
    end else begin
      s <= next_s;
    end
  end

  // ready is combinational so a full group stalls the source in the same cycle
  assign o_tx_bit_rdy  = !s.tx_full;
  assign o_tx_code     = s.tx_code;
  assign o_tx_code_vld = s.code_vld;
  assign o_sym_tick    = s.sym_tick;
  assign o_tx_locked   = (s.tx_mode == ctsc_pkg::CTSC_LOCKED);
  assign o_rx_data     = s.rx_data;
  assign o_rx_len      = s.rx_len;
  assign o_rx_vld      = s.rx_vld;
  assign o_rx_locked   = (s.rx_mode == ctsc_pkg::CTSC_LOCKED);

  // checks
  localparam int MAX_SYM_GAP = 900;
  logic tx_take;
  assign tx_take = i_tx_vld && o_tx_bit_rdy;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_group_full;
    tx_take ##1 !o_tx_bit_rdy;
  endsequence

  sequence s_symbol_out;
    ##[1:MAX_SYM_GAP] o_tx_code_vld;
  endsequence

  a_emit_on_tick: assert property (o_tx_code_vld |-> o_sym_tick) // see RQ17
    else $error("code word emitted off the symbol tick");

  a_tick_spacing: assert property (o_sym_tick |=> (!o_sym_tick) [*8]) // see RQ17
    else $error("symbol ticks too close together");

  a_group_drains: assert property (s_group_full |-> s_symbol_out) // see RQ6
    else $error("full group not emitted within one symbol period");

  a_emit_frees: assert property (o_tx_code_vld |-> o_tx_bit_rdy) // see RQ6
    else $error("ready not restored after emission");

  a_two_pair_width: assert property ( // see RQ8
    (o_tx_code_vld && $past(i_coded) && $past(!i_one_pair)) |-> !o_tx_code[6])
    else $error("two-pair coded word wider than six bits");

  a_uncoded_trel: assert property ( // see RQ3
    (o_tx_code_vld && $past(!i_coded)) |-> (s.tx_trel == ctsc_pkg::TREL_RST))
    else $error("trellis state moved in uncoded mode");

  a_lock_on_one: assert property ($rose(o_tx_locked) |-> // see RQ15
    $past(tx_take && i_tx_bit && i_lock_req))
    else $error("transmit lock entered on a zero bit");

  a_locked_feed: assert property ((tx_take && o_tx_locked && i_lock_req) |=> // see RQ14
    s.tx_hist[0] == ($past(s.tx_hist[ctsc_pkg::TAP_LONG]) ^
      ($past(i_exchange_side) ? $past(s.tx_hist[ctsc_pkg::TAP_EXCH])
                              : $past(s.tx_hist[ctsc_pkg::TAP_CUST]))))
    else $error("locked scrambler did not feed back its own sequence");

  a_self_feed: assert property ((tx_take && !o_tx_locked) |=> // see RQ12
    s.tx_hist[0] == s.tx_grp[$past(s.tx_cnt)])
    else $error("self-sync scrambler did not feed back its output");

  a_rx_answer: assert property (i_rx_vld |=> o_rx_vld ##1 (o_rx_len >= ctsc_pkg::GRP_TWO_PAIR
    || !$past(o_rx_vld))) // see RQ13
    else $error("receive word not answered next cycle");

  a_hold_stall: assert property ((i_tx_vld && !o_tx_bit_rdy) |=> $stable(s.tx_hist)) // see RQ16
    else $error("scrambler history moved while stalled");

  // reset must be checked while reset is low, so the default disable is overridden
  a_reset_idle: assert property (disable iff (1'b0) !i_rst_b |=> // see RQ20
    (o_tx_bit_rdy && !o_tx_locked && !o_rx_locked && !o_tx_code_vld && !o_rx_vld))
    else $error("outputs not idle after reset");

  // a receive word and its answer one cycle later
  sequence s_rx_taken;
    i_rx_vld ##1 o_rx_vld;
  endsequence

  a_rx_len_mode: assert property (s_rx_taken |-> // see RQ6 see RQ9
    o_rx_len == 3'(($past(i_one_pair) ? ctsc_pkg::GRP_ONE_PAIR : ctsc_pkg::GRP_TWO_PAIR)
                   + {2'b00, $past(!i_coded)}))
    else $error("receive length does not match the mode");

  // bits above the group length must never leak stale data
  a_rx_upper_zero: assert property (o_rx_vld |-> ((o_rx_data >> o_rx_len) == 7'h00)) // see RQ5
    else $error("receive data has bits above its length");

  // dropping the lock request returns both scramblers at once
  a_unlock_both: assert property (!i_lock_req |=> (!o_rx_locked && !o_tx_locked)) // see RQ15
    else $error("scrambler stayed locked without a lock request");

  a_rx_lock_on_one: assert property ($rose(o_rx_locked) |-> // see RQ15
    (o_rx_vld && (o_rx_data != 7'h00)))
    else $error("receive lock entered without a descrambled one");

  // once locked, only the request may release the generator
  a_tx_lock_held: assert property ((o_tx_locked && i_lock_req) |=> o_tx_locked) // see RQ14
    else $error("transmit scrambler left locked mode on its own");

  a_rx_lock_held: assert property ((o_rx_locked && i_lock_req) |=> o_rx_locked) // see RQ14
    else $error("receive descrambler left locked mode on its own");

  // no partial group is ever emitted
  a_full_before_emit: assert property (o_tx_code_vld |-> $past(!o_tx_bit_rdy)) // see RQ5
    else $error("code word emitted from a partial group");

  // uncoded two-pair words carry six group bits and no redundant bit
  a_uncoded_width: assert property ( // see RQ3
    (o_tx_code_vld && $past(!i_coded) && $past(!i_one_pair)) |-> !o_tx_code[6])
    else $error("uncoded two-pair word wider than six bits");
endmodule // ctsc_codec
`default_nettype wire

/* File: verilog/ctsc_trellis_enc.sv */
// Purpose: 8-state systematic convolutional encoder step, no differential part
// Assumes: caller holds the state register and advances it once per coded symbol
// Notes:   feedback taps are a parameter-free fixed network; swap here if needed
`default_nettype none
module ctsc_trellis_enc (
  input  wire logic [2:0] i_state,
  input  wire logic       i_group_first_info_bit,
  input  wire logic       i_group_second_info_bit,
  output logic            o_trellis_redundant_bit,
  output logic [2:0]      o_next_state
);
  // systematic: info bits pass untouched, only the parity bit is generated
  assign o_trellis_redundant_bit = i_state[0];
  assign o_next_state = {i_state[0] ^ i_group_first_info_bit,
                         i_state[2] ^ i_group_second_info_bit,
                         i_state[1] ^ i_group_first_info_bit};
endmodule // ctsc_trellis_enc
`default_nettype wire
